// [inc/msev_map.vh]
// event codes, control word fields and reset values for the mesh stop event select
// Functional notes
// - code 0x87 adds agent one request credits in use, points 8-15, mask bit each.
// - codes 0x8C/0x8D add agent one payload credits acquired, points 0-7 / 8-15.
// - codes 0x8E/0x8F add agent one payload credits in use, points 0-7 / 8-15.
// - code 0xAF counts distress cycles; bits 0-3 vertical, horizontal, local, remote throttle.
// - vertical distress asserts while ingress request queue full; agents throttle requests.
// - horizontal distress asserts while crossing point egress full; agents throttle requests.
// - 0xAF bit 4 local persistent memory throttle, bit 5 same from another tile.
// - 0xAF bit 6 throttle stalled by snoop arrivals, bit 7 stalled for no credit.
// - code 0xBA counts snoop egress ordering holds; bit 0 up, bit 2 down.
// - ring busy counts passing or sunk packets, never packets this stop injects.
// - 0xB6 request, 0xB7 ack, 0xB8 payload, 0xBB credit; bits le, lo, re, ro.
// - left half stops map up to clockwise, right half stops reverse that mapping.
// - code 0xB9 counts single snoop ring use; bit 0 left, bit 2 right.
// - code 0xE6 counts external error flag cycles; bit 0 instance 0, bit 1 instance 1.
// - code 0xAC counts horizontal bounces; bits 0-3 request, ack, payload, snoop.
// - code 0xAA counts vertical bounces; bits 0-4 request, ack, payload, snoop, credit.
// - code 0xC0 is accepted as the stop clock tick event.
`ifndef MSEV_MAP_VH
`define MSEV_MAP_VH

`define MSEV_CODE_LSB        0
`define MSEV_CODE_MSB        7
`define MSEV_MASK_LSB        8
`define MSEV_MASK_MSB        15
`define MSEV_CTL_RESET       16'h0000

`define MSEV_EV_REQ_USE_HI   8'h87
`define MSEV_EV_PAY_GET_LO   8'h8C
`define MSEV_EV_PAY_GET_HI   8'h8D
`define MSEV_EV_PAY_USE_LO   8'h8E
`define MSEV_EV_PAY_USE_HI   8'h8F
`define MSEV_EV_VERT_BOUNCE  8'hAA
`define MSEV_EV_HORZ_BOUNCE  8'hAC
`define MSEV_EV_DISTRESS     8'hAF
`define MSEV_EV_HREQ_BUSY    8'hB6
`define MSEV_EV_HACK_BUSY    8'hB7
`define MSEV_EV_HPAY_BUSY    8'hB8
`define MSEV_EV_HSNP_BUSY    8'hB9
`define MSEV_EV_EGR_ORDER    8'hBA
`define MSEV_EV_HCRD_BUSY    8'hBB
`define MSEV_EV_TICKS        8'hC0
`define MSEV_EV_EXT_ERR      8'hE6

`endif

// [verilog/msev_credit_sum.v]
// masked sum of per crossing point credit counts
`default_nettype none

module msev_credit_sum #(
    parameter N  = 8,
    parameter CW = 4,
    parameter SW = 7
) (
    // per point counts, point 0 in the low bits
    input  wire [N*CW-1:0] cnt_i,
    // one select bit per point
    input  wire [N-1:0]    sel_i,
    // sum of the selected counts
    output reg  [SW-1:0]   sum_o
);
    integer k;

    always @* begin
        sum_o = {SW{1'b0}};
        for (k = 0; k < N; k = k + 1) begin
            if (sel_i[k]) begin
                sum_o = sum_o + {{(SW-CW){1'b0}}, cnt_i[k*CW +: CW]};
            end
        end
    end

endmodule
`default_nettype wire

// [verilog/msev_distress.v]
// distress generation for request throttling at the stop
`default_nettype none

module msev_distress (
    // clock and reset
    input  wire clk_i,
    input  wire rst_i,
    // local queue state
    input  wire ingress_req_full_i,
    input  wire egress_full_i,
    // distress arriving from other stops
    input  wire vert_in_i,
    input  wire horz_in_i,
    // local and seen distress, and agent throttle
    output reg  vert_local_o,
    output reg  horz_local_o,
    output reg  vert_seen_o,
    output reg  horz_seen_o,
    output reg  req_throttle_o
);
    always @(posedge clk_i) begin
        if (rst_i) begin
            vert_local_o   <= 1'b0;
            horz_local_o   <= 1'b0;
            vert_seen_o    <= 1'b0;
            horz_seen_o    <= 1'b0;
            req_throttle_o <= 1'b0;
        end else begin
            vert_local_o   <= ingress_req_full_i;
            horz_local_o   <= egress_full_i;
            vert_seen_o    <= ingress_req_full_i | vert_in_i;
            horz_seen_o    <= egress_full_i | horz_in_i;
            // agents back off request ring traffic under either distress
            req_throttle_o <= ingress_req_full_i | egress_full_i;
        end
    end

endmodule
`default_nettype wire

// [verilog/msev_top.v]
// event select for one mesh stop performance counter
`include "msev_map.vh"
`default_nettype none

module msev_top #(
    parameter CW        = 4,
    parameter INC_W     = 8,
    parameter NUM_STOPS = 8,
    parameter STOP_IDX  = 0
) (
    // clock and reset
    input  wire                clk_i,
    input  wire                rst_i,
    // counter control word: code in 7:0, unit mask in 15:8
    input  wire                ctl_wr_i,
    input  wire [15:0]         ctl_word_i,
    // agent one credit counts, point 0 lowest
    input  wire [8*CW-1:0]     req_credit_use_high_i,
    input  wire [16*CW-1:0]    pay_credit_get_i,
    input  wire [16*CW-1:0]    pay_credit_use_i,
    // local and incoming distress sources
    input  wire                ingress_req_full_i,
    input  wire                egress_full_i,
    input  wire                vert_distress_in_i,
    input  wire                horz_distress_in_i,
    input  wire                throttle_local_i,
    input  wire                throttle_remote_i,
    input  wire                pmem_local_i,
    input  wire                pmem_remote_i,
    input  wire                throttle_stall_snoop_i,
    input  wire                throttle_stall_nocrd_i,
    // snoop egress ordering holds
    input  wire                snoop_hold_up_i,
    input  wire                snoop_hold_dn_i,
    // horizontal ring occupancy {ccw_odd, ccw_even, cw_odd, cw_even}
    input  wire [3:0]          hreq_pass_i,
    input  wire [3:0]          hreq_sink_i,
    input  wire [3:0]          hack_pass_i,
    input  wire [3:0]          hack_sink_i,
    input  wire [3:0]          hpay_pass_i,
    input  wire [3:0]          hpay_sink_i,
    input  wire [3:0]          hcrd_pass_i,
    input  wire [3:0]          hcrd_sink_i,
    // snoop ring occupancy {ccw, cw}
    input  wire [1:0]          hsnp_pass_i,
    input  wire [1:0]          hsnp_sink_i,
    // external error flags per core interface instance
    input  wire [1:0]          ext_err_i,
    // bounces: horizontal {snp,pay,ack,req}, vertical {crd,snp,pay,ack,req}
    input  wire [3:0]          horz_bounce_i,
    input  wire [4:0]          vert_bounce_i,
    // counter side
    output reg  [INC_W-1:0]    inc_o,
    output reg                 ev_known_o,
    output reg  [15:0]         ctl_o,
    // distress toward the agents
    output wire                vert_distress_o,
    output wire                horz_distress_o,
    output wire                req_throttle_o
);
    localparam SW = CW + 4;

    // any selected condition true
    function any_sel;
        input [7:0] mask;
        input [7:0] cond;
        begin
            any_sel = |(mask & cond);
        end
    endfunction

    // reorder cw/ccw occupancy into up/down as seen from this stop
    function [3:0] to_updn;
        input [3:0] v;
        input       left;
        begin
            if (left) begin
                to_updn = v;
            end else begin
                to_updn = {v[1:0], v[3:2]};
            end
        end
    endfunction

    // widen a single flag to the increment width
    function [INC_W-1:0] one_bit;
        input b;
        begin
            one_bit = {{(INC_W-1){1'b0}}, b};
        end
    endfunction

    reg  [15:0]      ctl_reg;
    reg  [INC_W-1:0] inc_next;
    reg              known_next;

    wire [7:0] code = ctl_reg[`MSEV_CODE_MSB:`MSEV_CODE_LSB];
    wire [7:0] mask = ctl_reg[`MSEV_MASK_MSB:`MSEV_MASK_LSB];

    // first half of the stops sits on the left
    wire on_left = (STOP_IDX < (NUM_STOPS / 2));

    // control word latch; counting assumes it was loaded first
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctl_reg <= `MSEV_CTL_RESET;
        end else if (ctl_wr_i) begin
            ctl_reg <= ctl_word_i;
        end
    end

    // credit sums
    wire [SW-1:0] req_use_hi_sum;
    wire [SW-1:0] pay_get_lo_sum;
    wire [SW-1:0] pay_get_hi_sum;
    wire [SW-1:0] pay_use_lo_sum;
    wire [SW-1:0] pay_use_hi_sum;

    msev_credit_sum #(.N(8), .CW(CW), .SW(SW)) u_req_use_hi (
        .cnt_i (req_credit_use_high_i),
        .sel_i (mask),
        .sum_o (req_use_hi_sum)
    );

    msev_credit_sum #(.N(8), .CW(CW), .SW(SW)) u_pay_get_lo (
        .cnt_i (pay_credit_get_i[8*CW-1:0]),
        .sel_i (mask),
        .sum_o (pay_get_lo_sum)
    );

    msev_credit_sum #(.N(8), .CW(CW), .SW(SW)) u_pay_get_hi (
        .cnt_i (pay_credit_get_i[16*CW-1:8*CW]),
        .sel_i (mask),
        .sum_o (pay_get_hi_sum)
    );

    msev_credit_sum #(.N(8), .CW(CW), .SW(SW)) u_pay_use_lo (
        .cnt_i (pay_credit_use_i[8*CW-1:0]),
        .sel_i (mask),
        .sum_o (pay_use_lo_sum)
    );

    msev_credit_sum #(.N(8), .CW(CW), .SW(SW)) u_pay_use_hi (
        .cnt_i (pay_credit_use_i[16*CW-1:8*CW]),
        .sel_i (mask),
        .sum_o (pay_use_hi_sum)
    );

    // distress
    wire vert_seen;
    wire horz_seen;

    msev_distress u_distress (
        .clk_i              (clk_i),
        .rst_i              (rst_i),
        .ingress_req_full_i (ingress_req_full_i),
        .egress_full_i      (egress_full_i),
        .vert_in_i          (vert_distress_in_i),
        .horz_in_i          (horz_distress_in_i),
        .vert_local_o       (vert_distress_o),
        .horz_local_o       (horz_distress_o),
        .vert_seen_o        (vert_seen),
        .horz_seen_o        (horz_seen),
        .req_throttle_o     (req_throttle_o)
    );

    // distress is one cycle behind the raw queue state, so the
    // remaining sources are delayed to line up with it
    reg [5:0] dist_src_reg;

    always @(posedge clk_i) begin
        if (rst_i) begin
            dist_src_reg <= 6'h00;
        end else begin
            dist_src_reg <= {throttle_stall_nocrd_i, throttle_stall_snoop_i,
                             pmem_remote_i, pmem_local_i,
                             throttle_remote_i, throttle_local_i};
        end
    end

    wire [7:0] dist_vec = {dist_src_reg[5:4],
                           dist_src_reg[3:2],
                           dist_src_reg[1:0],
                           horz_seen, vert_seen};

    // ring occupancy: pass or sink only, injections never reach here
    wire [3:0] hreq_occ = to_updn(hreq_pass_i | hreq_sink_i, on_left);
    wire [3:0] hack_occ = to_updn(hack_pass_i | hack_sink_i, on_left);
    wire [3:0] hpay_occ = to_updn(hpay_pass_i | hpay_sink_i, on_left);
    wire [3:0] hcrd_occ = to_updn(hcrd_pass_i | hcrd_sink_i, on_left);
    wire [1:0] hsnp_raw = hsnp_pass_i | hsnp_sink_i;

    // up side lands on mask bit 0, down side on bit 2
    wire [1:0] hsnp_occ = on_left ? hsnp_raw : {hsnp_raw[0], hsnp_raw[1]};
    wire [7:0] hsnp_vec = {5'h00, hsnp_occ[1], 1'b0, hsnp_occ[0]};

    wire [7:0] order_vec = {5'h00, snoop_hold_dn_i, 1'b0, snoop_hold_up_i};

    // selection
    always @* begin
        inc_next   = {INC_W{1'b0}};
        known_next = 1'b1;
        case (code)
            `MSEV_EV_REQ_USE_HI: begin
                inc_next = req_use_hi_sum[INC_W-1:0];
            end
            `MSEV_EV_PAY_GET_LO: begin
                inc_next = pay_get_lo_sum[INC_W-1:0];
            end
            `MSEV_EV_PAY_GET_HI: begin
                inc_next = pay_get_hi_sum[INC_W-1:0];
            end
            `MSEV_EV_PAY_USE_LO: begin
                inc_next = pay_use_lo_sum[INC_W-1:0];
            end
            `MSEV_EV_PAY_USE_HI: begin
                inc_next = pay_use_hi_sum[INC_W-1:0];
            end
            `MSEV_EV_DISTRESS: begin
                inc_next = one_bit(any_sel(mask, dist_vec));
            end
            `MSEV_EV_EGR_ORDER: begin
                inc_next = one_bit(any_sel(mask, order_vec));
            end
            `MSEV_EV_HREQ_BUSY: begin
                inc_next = one_bit(any_sel(mask, {4'h0, hreq_occ}));
            end
            `MSEV_EV_HACK_BUSY: begin
                inc_next = one_bit(any_sel(mask, {4'h0, hack_occ}));
            end
            `MSEV_EV_HPAY_BUSY: begin
                inc_next = one_bit(any_sel(mask, {4'h0, hpay_occ}));
            end
            `MSEV_EV_HCRD_BUSY: begin
                inc_next = one_bit(any_sel(mask, {4'h0, hcrd_occ}));
            end
            `MSEV_EV_HSNP_BUSY: begin
                inc_next = one_bit(any_sel(mask, hsnp_vec));
            end
            `MSEV_EV_EXT_ERR: begin
                inc_next = one_bit(any_sel(mask, {6'h00, ext_err_i}));
            end
            `MSEV_EV_HORZ_BOUNCE: begin
                inc_next = one_bit(any_sel(mask, {4'h0, horz_bounce_i}));
            end
            `MSEV_EV_VERT_BOUNCE: begin
                inc_next = one_bit(any_sel(mask, {3'h0, vert_bounce_i}));
            end
            `MSEV_EV_TICKS: begin
                inc_next = one_bit(1'b1);
            end
            default: begin
                inc_next   = {INC_W{1'b0}};
                known_next = 1'b0;
            end
        endcase
    end

    // registered outputs toward the counter
    always @(posedge clk_i) begin
        if (rst_i) begin
            inc_o      <= {INC_W{1'b0}};
            ev_known_o <= 1'b0;
            ctl_o      <= `MSEV_CTL_RESET;
        end else begin
            inc_o      <= inc_next;
            ev_known_o <= known_next;
            ctl_o      <= ctl_reg;
        end
    end

endmodule
`default_nettype wire

// [testbench/msev_top_properties.sv]
// port-level checks for the mesh stop event select
`default_nettype none
module msev_top_properties #(
    parameter int INC_W = 8
) (
    // clock and reset
    input wire logic             clk_i,
    input wire logic             rst_i,
    // control word
    input wire logic             ctl_wr_i,
    input wire logic [15:0]      ctl_word_i,
    // sources
    input wire logic             ingress_req_full_i,
    input wire logic             egress_full_i,
    input wire logic [1:0]       ext_err_i,
    input wire logic [3:0]       horz_bounce_i,
    input wire logic [4:0]       vert_bounce_i,
    // outputs
    input wire logic [INC_W-1:0] inc_o,
    input wire logic             ev_known_o,
    input wire logic [15:0]      ctl_o,
    input wire logic             vert_distress_o,
    input wire logic             horz_distress_o,
    input wire logic             req_throttle_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ctl_o lags the loaded word by one edge, so it names the code behind inc_o
    chk_ctl_load: assert property (ctl_wr_i |->
        ##2 ctl_o == $past(ctl_word_i, 2)) else $error("control word not shown");
    chk_tick_one: assert property (ctl_wr_i && ctl_word_i[7:0] == 8'hC0 |->
        ##2 inc_o == 1 && ev_known_o) else $error("tick event not one per cycle");
    chk_unknown_zero: assert property (!ev_known_o |-> inc_o == '0)
        else $error("unknown code adds");
    chk_vert_dist: assert property (1 |=>
        vert_distress_o == $past(ingress_req_full_i)) else $error("vertical distress");
    chk_horz_dist: assert property (1 |=>
        horz_distress_o == $past(egress_full_i)) else $error("horizontal distress");
    chk_throttle_or: assert property (1 |=> req_throttle_o ==
        ($past(ingress_req_full_i) || $past(egress_full_i))) else $error("throttle");
    chk_ext_err: assert property (ctl_o[7:0] == 8'hE6 |->
        inc_o == INC_W'(|($past(ext_err_i) & ctl_o[9:8]))) else $error("error flag count");
    chk_bounce_h: assert property (ctl_o[7:0] == 8'hAC |->
        inc_o == INC_W'(|($past(horz_bounce_i) & ctl_o[11:8]))) else $error("h bounce");
    chk_bounce_v: assert property (ctl_o[7:0] == 8'hAA |->
        inc_o == INC_W'(|($past(vert_bounce_i) & ctl_o[12:8]))) else $error("v bounce");
    cov_distress: cover property (ctl_o[7:0] == 8'hAF && inc_o == 1);
    cov_credit_sum: cover property (inc_o > 8);
    cov_throttle: cover property (vert_distress_o && !horz_distress_o);
endmodule
bind msev_top msev_top_properties #(.INC_W(INC_W)) msev_top_properties_inst (.*);
`default_nettype wire

// [testbench/msev_count_model.sv]
// counter model that accumulates the selected increment
`default_nettype none
module msev_count_model #(
    parameter int INC_W = 8
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // a control load restarts the count
    input  wire logic             clr_i,
    input  wire logic [INC_W-1:0] inc_i,
    // running total
    output logic      [31:0]      total_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // restart on load; the increment already registered under the old selection is still added on the next edge
    always @(posedge clk_i) begin
        if (rst_i || clr_i)
            total_o <= 32'h0;
        else
            total_o <= total_o + 32'(inc_i);
    end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench for the mesh stop event select
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CW = 4;
    localparam int INC_W = 8;
    localparam logic [7:0] RC [4] = '{8'hB6, 8'hB7, 8'hB8, 8'hBB};
    logic clk_i, rst_i, ctl_wr_i, ev_known_o, vert_distress_o, horz_distress_o, req_throttle_o;
    logic ingress_req_full_i, egress_full_i, vert_distress_in_i, horz_distress_in_i;
    logic throttle_local_i, throttle_remote_i, pmem_local_i, pmem_remote_i;
    logic throttle_stall_snoop_i, throttle_stall_nocrd_i, snoop_hold_up_i, snoop_hold_dn_i;
    logic [3:0] hreq_pass_i, hreq_sink_i, hack_pass_i, hack_sink_i, horz_bounce_i;
    logic [3:0] hpay_pass_i, hpay_sink_i, hcrd_pass_i, hcrd_sink_i;
    logic [1:0] hsnp_pass_i, hsnp_sink_i, ext_err_i;
    logic [4:0] vert_bounce_i;
    logic [15:0] ctl_word_i, ctl_o;
    logic [8*CW-1:0] req_credit_use_high_i;
    logic [16*CW-1:0] pay_credit_get_i, pay_credit_use_i;
    logic [INC_W-1:0] inc_o, inc_right;
    logic [31:0] total;
    int mismatches, comparisons, k;
    msev_top #(.CW(CW), .INC_W(INC_W)) msev_top_inst (.*);
    // a right-half stop sees the ring directions swapped
    msev_top #(.CW(CW), .INC_W(INC_W), .STOP_IDX(4)) msev_top_right_inst (.*,
        .inc_o(inc_right), .ev_known_o(), .ctl_o(), .vert_distress_o(), .horz_distress_o(),
        .req_throttle_o());
    msev_count_model #(.INC_W(INC_W)) msev_count_model_inst (.clk_i(clk_i), .rst_i(rst_i),
        .clr_i(ctl_wr_i), .inc_i(inc_o), .total_o(total));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic fill(input logic v);
        {req_credit_use_high_i, pay_credit_get_i, pay_credit_use_i, ingress_req_full_i,
         egress_full_i, vert_distress_in_i, horz_distress_in_i, throttle_local_i,
         throttle_remote_i, pmem_local_i, pmem_remote_i, throttle_stall_snoop_i,
         throttle_stall_nocrd_i, snoop_hold_up_i, snoop_hold_dn_i, hreq_pass_i, hreq_sink_i,
         hack_pass_i, hack_sink_i, hpay_pass_i, hpay_sink_i, hcrd_pass_i, hcrd_sink_i,
         hsnp_pass_i, hsnp_sink_i, ext_err_i, horz_bounce_i, vert_bounce_i} = v ? '1 : '0;
    endtask
    // load a control word, hold the sources, check inc_o after the latency
    task automatic ev(input logic [15:0] w, input logic [31:0] exp, input int lat);
        @(negedge clk_i);
        ctl_wr_i = 1'b1;
        ctl_word_i = w;
        @(negedge clk_i);
        ctl_wr_i = 1'b0;
        repeat (lat) @(negedge clk_i);
        cmp(inc_o, exp);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        stop_test();
    end
    initial begin
        mismatches = 0;
        comparisons = 0;
        rst_i = 1'b1;
        ctl_wr_i = 1'b0;
        ctl_word_i = 16'h0000;
        fill(1'b0);
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        cmp({ctl_o, ev_known_o, inc_o}, 0);
        ev(16'hFFC0, 1, 1);
        cmp({ctl_o, ev_known_o}, {16'hFFC0, 1'b1});
        k = total;
        repeat (5) @(negedge clk_i);
        cmp(total, k + 5);
        $display("test ticks done");
        for (k = 0; k < 16; k++) begin
            pay_credit_get_i[k*CW +: CW] = CW'(k);
            pay_credit_use_i[k*CW +: CW] = CW'(15 - k);
            if (k < 8)
                req_credit_use_high_i[k*CW +: CW] = CW'(k + 1);
        end
        ev(16'h8187, 9, 1);
        ev(16'h068C, 3, 1);
        ev(16'h818D, 23, 1);
        ev(16'hFF8D, 92, 1);
        ev(16'h068E, 27, 1);
        ev(16'hFF8F, 28, 1);
        $display("test credits done");
        fill(1'b0);
        for (k = 0; k < 8; k++) begin
            {throttle_stall_nocrd_i, throttle_stall_snoop_i, pmem_remote_i, pmem_local_i,
             throttle_remote_i, throttle_local_i, egress_full_i, ingress_req_full_i} = 8'h01 << k;
            ev({8'h01 << k, 8'hAF}, 1, 2);
            ev({~(8'h01 << k), 8'hAF}, 0, 2);
        end
        fill(1'b0);
        vert_distress_in_i = 1'b1;
        ev(16'h01AF, 1, 2);
        ev(16'h02AF, 0, 2);
        {vert_distress_in_i, horz_distress_in_i} = 2'b01;
        ev(16'h02AF, 1, 2);
        ev(16'hFDAF, 0, 2);
        for (k = 0; k < 2; k++) begin
            fill(1'b0);
            {egress_full_i, ingress_req_full_i} = 2'b01 << k;
            repeat (2) @(negedge clk_i);
            cmp({horz_distress_o, vert_distress_o, req_throttle_o}, {2'b01 << k, 1'b1});
        end
        $display("test distress done");
        fill(1'b0);
        hreq_pass_i = 4'b0001;
        hack_sink_i = 4'b0010;
        hpay_pass_i = 4'b0100;
        hcrd_sink_i = 4'b1000;
        hsnp_sink_i = 2'b10;
        snoop_hold_dn_i = 1'b1;
        ext_err_i = 2'b10;
        for (k = 0; k < 4; k++) begin
            ev({8'h01 << k, RC[k]}, 1, 1);
            cmp(inc_right, 0);
            ev({~(8'h01 << k), RC[k]}, 0, 1);
            cmp(inc_right, 1);
        end
        ev(16'h04B9, 1, 1);
        cmp(inc_right, 0);
        ev(16'hFBB9, 0, 1);
        cmp(inc_right, 1);
        ev(16'h04BA, 1, 1);
        ev(16'hFBBA, 0, 1);
        {snoop_hold_up_i, snoop_hold_dn_i} = 2'b10;
        ev(16'h01BA, 1, 1);
        ev(16'hFEBA, 0, 1);
        ev(16'h02E6, 1, 1);
        ev(16'hFDE6, 0, 1);
        ext_err_i = 2'b01;
        ev(16'h01E6, 1, 1);
        ev(16'hFEE6, 0, 1);
        $display("test rings done");
        for (k = 0; k < 5; k++) begin
            fill(1'b0);
            horz_bounce_i = 4'(5'h01 << k);
            vert_bounce_i = 5'h01 << k;
            ev({8'h01 << k, 8'hAC}, k < 4, 1);
            ev({8'h01 << k, 8'hAA}, 1, 1);
            ev({~(8'h01 << k), 8'hAA}, 0, 1);
        end
        $display("test bounces done");
        fill(1'b1);
        ev(16'hFF55, 0, 1);
        cmp(ev_known_o, 0);
        $display("test unknown done");
        stop_test();
    end
endmodule
`default_nettype wire
